// File: asc_adc_ctrl.sv
// Converter control and result block with an AXI4-Lite register slave.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/10ps

// Overview of operation
// RULE1: Ladder connected only during conversion when clear, always when set.
// RULE2: Time code 000,010,011,100,101,110 gives 39,78,156,312,624,1248 clock cycles.
// RULE3: Software writes zero to timing bit 0 and one to bit 4.
// RULE4: Timing register bits 7 and 6 read as undefined.
// RULE5: Standby resets timing register and blocks writes until normal mode.
// RULE6: Software keeps conversion time at or above the analog minimum.
// RULE7: Ten-bit result: upper eight in high register, low two in bits 7..6.
// RULE8: Done flag at bit 5 reads 0 before and during, 1 after conversion.
// RULE9: Reading high result register clears the done flag.
// RULE10: Software reads low result register before the high one.
// RULE11: Busy flag set at start, cleared at finish and on standby.
// RULE12: Low result bits 3..0 return meaningless values.
// RULE13: Software mode: start bit begins one conversion of selected channel.
// RULE14: Completion stores result, sets done flag and raises interrupt together.
// RULE15: Start bit clears itself once the conversion begins.
// RULE16: Software does not set start again during a conversion.
// RULE17: Repeat mode: each completed conversion starts the next one.
// RULE18: Writing mode 00 stops at once and discards the running result.
// RULE19: A new start clears done; old result stays until new completion.
// RULE20: Standby during conversion aborts it and resets both control registers and results.
// RULE21: No automatic restart after standby; ladder disconnected in standby.
// RULE22: Mode 00 disabled, 01 software, 10 reserved, 11 repeat; start at bit 7.
// RULE23: Channel codes 0000 to 0111 select inputs 0 to 7, others reserved.
// RULE24: Software changes channel only while busy reads zero.
// RULE25: Conversion timed by counting selected cycles; completes on expiry.
module asc_adc_ctrl
    import asc_pkg::*;
(
    input  wire logic                  clock,
    input  wire logic                  nrst,
    input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [ADDR_W-1:0]     s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire logic                  standby_req,
    input  wire logic                  comparator_out,
    input  wire logic [9:0]            sar_code,
    output asc_analog_ctl_t            analog_ctl,
    output logic                       conv_done_irq
);

    // ==========================================================================
    // Declarations.
    typedef enum logic [1:0] {
        ASC_ST_IDLE = 2'b00,
        ASC_ST_CONV = 2'b01,
        ASC_ST_DONE = 2'b10
    } asc_state_t;

    asc_state_t        state_r;
    logic [7:0]        mode_control_r;
    logic [7:0]        timing_control_r;
    logic [9:0]        result_r;
    logic              done_r;
    logic [10:0]       count_r;
    logic [1:0]        stby_sync_r;
    logic [9:0]        code_s1_r;
    logic [9:0]        code_s2_r;
    logic              cmp_s1_r;
    logic              cmp_s2_r;
    logic [3:0]        noise_r;
    logic              aw_held_r;
    logic              w_held_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [31:0]       wdata_r;
    logic [3:0]        wstrb_r;
    logic              standby;
    logic              wr_go;
    logic              rd_go;
    logic [7:0]        wr_idx;
    logic [7:0]        rd_idx;
    logic              wr_mode;
    logic              wr_time;
    logic              start_now;
    logic              finish_now;
    logic              rd_high;
    asc_mode_t         mode;
    logic [10:0]       conv_len;

    // ==========================================================================
    // Helper functions.
    function automatic logic [10:0] conv_cycles(input logic [2:0] code);
        case (code)
            3'b000:  conv_cycles = CONV_CYC_39;
            3'b010:  conv_cycles = CONV_CYC_78;
            3'b011:  conv_cycles = CONV_CYC_156;
            3'b100:  conv_cycles = CONV_CYC_312;
            3'b101:  conv_cycles = CONV_CYC_624;
            3'b110:  conv_cycles = CONV_CYC_1248;
            default: conv_cycles = CONV_CYC_1248;
        endcase
    endfunction : conv_cycles

    function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] addr);
        word_index = addr[9:2];
    endfunction : word_index

    function automatic logic addr_ok(input logic [ADDR_W-1:0] addr);
        addr_ok = (addr[1:0] == 2'h0) && (addr[ADDR_W-1:10] == 2'h0);
    endfunction : addr_ok

    // ==========================================================================
    // Input synchronisers.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            stby_sync_r <= 2'h0;
            code_s1_r   <= 10'h000;
            code_s2_r   <= 10'h000;
            cmp_s1_r    <= 1'b0;
            cmp_s2_r    <= 1'b0;
        end else begin
            stby_sync_r <= {stby_sync_r[0], standby_req};
            code_s1_r   <= sar_code;
            code_s2_r   <= code_s1_r;
            cmp_s1_r    <= comparator_out;
            cmp_s2_r    <= cmp_s1_r;
        end
    end

    assign standby = stby_sync_r[1];

    // Free running pattern that fills the meaningless low status bits.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            noise_r <= 4'h0;
        end else begin
            noise_r <= {noise_r[2:0], cmp_s2_r ^ noise_r[3]}; // RULE12
        end
    end

    // ==========================================================================
    // Bus decode.
    assign wr_go     = aw_held_r && w_held_r && !s_axi_bvalid;
    assign rd_go     = s_axi_arvalid && s_axi_arready;
    assign wr_idx    = word_index(awaddr_r);
    assign rd_idx    = word_index(s_axi_araddr);
    assign wr_mode   = wr_go && addr_ok(awaddr_r) && (wr_idx == IDX_MODE_CONTROL) && wstrb_r[0] && !standby;
    assign wr_time   = wr_go && addr_ok(awaddr_r) && (wr_idx == IDX_TIMING_CONTROL) && wstrb_r[0] && !standby; // RULE5
    assign rd_high   = rd_go && addr_ok(s_axi_araddr) && (rd_idx == IDX_RESULT_HIGH);
    assign mode      = asc_mode_t'(mode_control_r[MC_MODE_LSB +: 2]);
    assign conv_len  = conv_cycles(timing_control_r[TC_TIME_LSB +: 3]); // RULE2
    assign start_now = (state_r != ASC_ST_CONV) && mode_control_r[MC_START_BIT]
                       && ((mode == ASC_MODE_SOFT) || (mode == ASC_MODE_REPEAT)) // RULE13 RULE22
                       && (mode_control_r[3] == 1'b0); // RULE23
    assign finish_now = (state_r == ASC_ST_CONV) && (count_r == 11'h001); // RULE25

    // ==========================================================================
    // AXI4-Lite write channel.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            aw_held_r     <= 1'b0;
            w_held_r      <= 1'b0;
            awaddr_r      <= '0;
            wdata_r       <= 32'h0000_0000;
            wstrb_r       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
        end else begin
            s_axi_awready <= !aw_held_r && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_held_r && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held_r    <= 1'b0;
                w_held_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (addr_ok(awaddr_r) && (wr_idx >= IDX_MODE_CONTROL)
                                 && (wr_idx <= IDX_POWER_STATE)) ? 2'h0 : 2'h2;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ==========================================================================
    // AXI4-Lite read channel.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'h0;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= 2'h0;
                s_axi_rdata  <= 32'h0000_0000;
                if (!addr_ok(s_axi_araddr)) begin
                    s_axi_rresp <= 2'h2;
                end else begin
                    case (rd_idx)
                        IDX_MODE_CONTROL:   s_axi_rdata[7:0] <= mode_control_r;
                        IDX_TIMING_CONTROL: s_axi_rdata[7:0] <= {noise_r[1:0], timing_control_r[5:0]}; // RULE4
                        IDX_RESULT_LOW: begin
                            s_axi_rdata[7:0] <= {result_r[1:0], done_r, state_r == ASC_ST_CONV, noise_r}; // RULE7 RULE8 RULE11 RULE12
                        end
                        IDX_RESULT_HIGH:    s_axi_rdata[7:0] <= result_r[9:2]; // RULE7
                        IDX_POWER_STATE:    s_axi_rdata[0]   <= standby;
                        default:            s_axi_rresp      <= 2'h2;
                    endcase
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ==========================================================================
    // Control registers.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            mode_control_r <= MODE_CONTROL_RST;
        end else if (standby) begin
            mode_control_r <= MODE_CONTROL_RST; // RULE20 RULE21
        end else if (wr_mode) begin
            mode_control_r <= wdata_r[7:0];
        end else if (start_now) begin
            mode_control_r[MC_START_BIT] <= 1'b0; // RULE15
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            timing_control_r <= TIMING_CONTROL_RST;
        end else if (standby) begin
            timing_control_r <= TIMING_CONTROL_RST; // RULE5 RULE20
        end else if (wr_time) begin
            timing_control_r <= wdata_r[7:0];
        end
    end

    // ==========================================================================
    // Conversion sequencer.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_r <= ASC_ST_IDLE;
            count_r <= 11'h000;
        end else if (standby || (mode == ASC_MODE_OFF)) begin
            state_r <= ASC_ST_IDLE; // RULE18 RULE20 RULE11
            count_r <= 11'h000;
        end else begin
            case (state_r)
                ASC_ST_IDLE, ASC_ST_DONE: begin
                    if (start_now) begin
                        state_r <= ASC_ST_CONV; // RULE11
                        count_r <= conv_len; // RULE25
                    end
                end
                ASC_ST_CONV: begin
                    if (finish_now) begin
                        if (mode == ASC_MODE_REPEAT) begin
                            count_r <= conv_len; // RULE17
                        end else begin
                            state_r <= ASC_ST_DONE;
                            count_r <= 11'h000;
                        end
                    end else begin
                        count_r <= count_r - 11'h001;
                    end
                end
                default: begin
                    state_r <= ASC_ST_IDLE;
                    count_r <= 11'h000;
                end
            endcase
        end
    end

    // ==========================================================================
    // Result, done flag and interrupt.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            result_r      <= RESULT_RST;
            done_r        <= 1'b0;
            conv_done_irq <= 1'b0;
        end else if (standby) begin
            result_r      <= RESULT_RST; // RULE20
            done_r        <= 1'b0;
            conv_done_irq <= 1'b0;
        end else begin
            conv_done_irq <= 1'b0;
            if (finish_now && (mode != ASC_MODE_OFF)) begin
                result_r      <= code_s2_r; // RULE14 RULE18
                done_r        <= 1'b1; // RULE8 RULE14
                conv_done_irq <= 1'b1; // RULE14
            end else if (start_now || rd_high) begin
                done_r <= 1'b0; // RULE9 RULE19
            end
        end
    end

    // ==========================================================================
    // Analog side control.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            analog_ctl <= '0;
        end else begin
            analog_ctl.sample        <= (state_r == ASC_ST_CONV) && !standby;
            analog_ctl.channel       <= mode_control_r[2:0];
            analog_ctl.ladder_on     <= !standby && (timing_control_r[TC_LADDER_BIT]
                                        || (state_r == ASC_ST_CONV)); // RULE1 RULE21
            analog_ctl.input_disable <= mode_control_r[MC_AIN_DIS_BIT];
        end
    end

endmodule : asc_adc_ctrl

// File: asc_adc_ctrl_checker.sv
// Concurrent checks on the ports of the converter control block.
`timescale 1ns/10ps
module asc_adc_ctrl_checker
    import asc_pkg::*;
(
    input wire logic            clock,
    input wire logic            nrst,
    input wire logic            s_axi_awvalid,
    input wire logic            s_axi_awready,
    input wire logic            s_axi_arvalid,
    input wire logic            s_axi_arready,
    input wire logic            s_axi_rvalid,
    input wire logic [31:0]     s_axi_rdata,
    input wire logic            s_axi_bvalid,
    input wire logic            standby_req,
    input wire asc_analog_ctl_t analog_ctl,
    input wire logic            conv_done_irq
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    chk_irq_one_pulse: assert property (conv_done_irq |=> !conv_done_irq)
        else $error("done interrupt longer than one cycle");
    chk_irq_ends_busy: assert property (conv_done_irq |-> $past(analog_ctl.sample) && $past(analog_ctl.sample, 8))
        else $error("done interrupt without a running conversion");
    chk_ladder_busy: assert property (analog_ctl.sample && $past(analog_ctl.sample) |-> analog_ctl.ladder_on)
        else $error("ladder off during conversion");
    chk_standby_quiet: assert property (standby_req [*5] |-> !analog_ctl.sample && !analog_ctl.ladder_on && !conv_done_irq)
        else $error("converter active in standby");
    chk_conv_min_len: assert property ($rose(analog_ctl.sample) && !standby_req |=> analog_ctl.sample [*8])
        else $error("conversion ended too early");
    chk_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
        else $error("write answer late");
    chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
endmodule : asc_adc_ctrl_checker

bind asc_adc_ctrl asc_adc_ctrl_checker u_chk (
    .clock(clock), .nrst(nrst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rdata(s_axi_rdata), .s_axi_bvalid(s_axi_bvalid), .standby_req(standby_req),
    .analog_ctl(analog_ctl), .conv_done_irq(conv_done_irq)
);

// File: asc_analog_model.sv
// Behavioural model of the comparator and input multiplexer; the ladder control is not used.
`timescale 1ns/10ps
module asc_analog_model
    import asc_pkg::*;
(
    input  wire logic            clock,
    input  wire asc_analog_ctl_t analog_ctl,
    output logic [9:0]           sar_code,
    output logic                 comparator_out
);
    logic [9:0] held_r;
    logic       toggle_r = 1'b0;

    // The code depends on the routed channel; outside sampling the lines show the inverse.
    always_ff @(posedge clock) begin
        held_r   <= {analog_ctl.channel, 7'h2a};
        toggle_r <= ~toggle_r;
    end
    assign sar_code       = analog_ctl.sample ? held_r : ~held_r;
    assign comparator_out = toggle_r;
endmodule : asc_analog_model

// File: asc_pkg.sv
// Package with register map, field positions, reset values and timing constants of the converter control.
package asc_pkg;

    // ==========================================================================
    // Register indices; the byte address on the bus is four times the index.
    localparam logic [7:0]  IDX_MODE_CONTROL   = 8'h1c;
    localparam logic [7:0]  IDX_TIMING_CONTROL = 8'h1d;
    localparam logic [7:0]  IDX_RESULT_LOW     = 8'h1e;
    localparam logic [7:0]  IDX_RESULT_HIGH    = 8'h1f;
    localparam logic [7:0]  IDX_POWER_STATE    = 8'h20;
    localparam int          ADDR_W             = 12;

    // ==========================================================================
    // Field positions.
    localparam int          MC_START_BIT       = 7;
    localparam int          MC_MODE_LSB        = 5;
    localparam int          MC_AIN_DIS_BIT     = 4;
    localparam int          TC_LADDER_BIT      = 5;
    localparam int          TC_TIME_LSB        = 1;
    localparam int          RL_DONE_BIT        = 5;
    localparam int          RL_BUSY_BIT        = 4;

    // ==========================================================================
    // Reset values.
    localparam logic [7:0]  MODE_CONTROL_RST   = 8'h10;
    localparam logic [7:0]  TIMING_CONTROL_RST = 8'h00;
    localparam logic [9:0]  RESULT_RST         = 10'h000;

    // ==========================================================================
    // Operating modes.
    typedef enum logic [1:0] {
        ASC_MODE_OFF    = 2'b00,
        ASC_MODE_SOFT   = 2'b01,
        ASC_MODE_RSVD   = 2'b10,
        ASC_MODE_REPEAT = 2'b11
    } asc_mode_t;

    // ==========================================================================
    // Conversion lengths in high-frequency clock cycles.
    localparam logic [10:0] CONV_CYC_39        = 11'h027;
    localparam logic [10:0] CONV_CYC_78        = 11'h04e;
    localparam logic [10:0] CONV_CYC_156       = 11'h09c;
    localparam logic [10:0] CONV_CYC_312       = 11'h138;
    localparam logic [10:0] CONV_CYC_624       = 11'h270;
    localparam logic [10:0] CONV_CYC_1248      = 11'h4e0;

    // ==========================================================================
    // Analog side signals.
    typedef struct packed {
        logic       sample;
        logic [2:0] channel;
        logic       ladder_on;
        logic       input_disable;
    } asc_analog_ctl_t;

endpackage : asc_pkg

// File: test_asc_adc_ctrl.sv
// Self-checking bench for the converter control block.
`timescale 1ns/10ps
module test_asc_adc_ctrl
    import asc_pkg::*;
;
    localparam logic [ADDR_W-1:0] A_MODE = ADDR_W'({IDX_MODE_CONTROL, 2'b00});
    localparam logic [ADDR_W-1:0] A_TIME = ADDR_W'({IDX_TIMING_CONTROL, 2'b00});
    localparam logic [ADDR_W-1:0] A_LOW  = ADDR_W'({IDX_RESULT_LOW, 2'b00});
    localparam logic [ADDR_W-1:0] A_HIGH = ADDR_W'({IDX_RESULT_HIGH, 2'b00});
    localparam logic [ADDR_W-1:0] A_STB  = ADDR_W'({IDX_POWER_STATE, 2'b00});
    logic                  clock = 1'b0;
    logic                  nrst = 1'b0;
    logic [ADDR_W-1:0]     s_axi_awaddr, s_axi_araddr;
    logic [31:0]           s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]            s_axi_wstrb;
    logic                  s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, standby_req;
    logic                  s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]            s_axi_bresp, s_axi_rresp, rsp;
    logic [9:0]            sar_code, e;
    logic                  comparator_out, conv_done_irq;
    asc_analog_ctl_t       analog_ctl;
    int                    num_errors = 0, samples_checked = 0, irq_cnt = 0, busy_cnt = 0, n;
    int                    lens [8] = '{39, 1248, 78, 156, 312, 624, 1248, 1248};

    asc_adc_ctrl u_dut (.clock, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .standby_req, .comparator_out, .sar_code, .analog_ctl, .conv_done_irq);
    asc_analog_model u_ana (.clock, .analog_ctl, .sar_code, .comparator_out);

    always #4 clock = ~clock;
    always @(negedge clock) begin
        if (conv_done_irq === 1'b1) irq_cnt++;
        if (analog_ctl.sample === 1'b1) busy_cnt++;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [ADDR_W-1:0] a);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_read

    task automatic wait_irq(input int base);
        while (irq_cnt == base) @(posedge clock);
    endtask : wait_irq

    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    initial begin
        repeat (60000) @(posedge clock);
        num_errors++;
        end_sim();
    end

    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, standby_req} = '0;
        s_axi_awaddr = '0;
        s_axi_araddr = '0;
        s_axi_wdata = '0;
        s_axi_wstrb = 4'hf;
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        axi_read(A_MODE);
        check(rd, 32'h00000010);
        axi_read(A_TIME);
        check(rd & 32'h3f, 32'h00000000);
        axi_read(A_HIGH);
        check(rd, 32'h00000000);
        axi_read(A_LOW);
        check(rd & 32'hf0, 32'h00000000);
        axi_read(12'h084);
        check(32'(rsp), 32'h2);
        $display("test reset values done");
        for (int c = 0; c < 8; c++) begin
            axi_write(A_TIME, 8'h10 | (8'(c) << 1) | (8'(c[0]) << 5));
            busy_cnt = 0;
            n = irq_cnt;
            axi_write(A_MODE, 8'ha0 | 8'(c));
            wait_irq(n);
            e = {3'(c), 7'h2a};
            check(32'(busy_cnt >= lens[c] - 1 && busy_cnt <= lens[c] + 1), 32'h1);
            axi_read(A_MODE);
            check(rd, 32'h20 | 32'(c));
            axi_read(A_LOW);
            check(rd & 32'hf0, {24'h0, e[1:0], 2'b10, 4'h0});
            axi_read(A_HIGH);
            check(rd, {24'h0, e[9:2]});
            axi_read(A_LOW);
            check(rd & 32'hf0, {24'h0, e[1:0], 6'h00});
            check(32'(analog_ctl.ladder_on), 32'(c[0]));
        end
        $display("test conversion times done");
        axi_write(A_TIME, 8'h10);
        n = irq_cnt;
        axi_write(A_MODE, 8'ha1);
        wait_irq(n);
        n = irq_cnt;
        axi_write(A_MODE, 8'ha2);
        axi_read(A_LOW);
        check(rd & 32'hf0, {24'h0, 2'b10, 2'b01, 4'h0});
        axi_read(A_HIGH);
        check(rd, {24'h0, 8'h2a});
        wait_irq(n);
        axi_read(A_HIGH);
        check(rd, {24'h0, 8'h4a});
        $display("test restart before read done");
        n = irq_cnt;
        axi_write(A_MODE, 8'he4);
        repeat (3) begin
            wait_irq(n);
            n = irq_cnt;
        end
        repeat (20) @(posedge clock);
        axi_write(A_MODE, 8'h04);
        repeat (5) @(posedge clock);
        check(32'(analog_ctl.sample), 32'h0);
        n = irq_cnt;
        repeat (100) @(posedge clock);
        check(irq_cnt, n);
        axi_write(A_MODE, 8'hc1);
        repeat (5) @(posedge clock);
        check(32'(analog_ctl.sample), 32'h0);
        axi_write(A_MODE, 8'ha8);
        repeat (5) @(posedge clock);
        check(32'(analog_ctl.sample), 32'h0);
        $display("test repeat mode done");
        axi_write(A_TIME, 8'h3c);
        axi_write(A_MODE, 8'ha6);
        repeat (50) @(posedge clock);
        n = irq_cnt;
        standby_req <= 1'b1;
        repeat (10) @(posedge clock);
        check(32'(analog_ctl.sample), 32'h0);
        axi_write(A_MODE, 8'ha1);
        axi_write(A_TIME, 8'h3c);
        axi_read(A_MODE);
        check(rd, 32'h00000010);
        axi_read(A_TIME);
        check(rd & 32'h3f, 32'h00000000);
        axi_read(A_LOW);
        check(rd & 32'h30, 32'h00000000);
        axi_read(A_STB);
        check(rd & 32'h1, 32'h1);
        axi_read(A_HIGH);
        check(rd, 32'h00000000);
        check(32'(analog_ctl.input_disable), 32'h1);
        standby_req <= 1'b0;
        repeat (200) @(posedge clock);
        check(irq_cnt, n);
        check(32'(analog_ctl.sample), 32'h0);
        axi_write(A_TIME, 8'h3c);
        axi_read(A_TIME);
        check(rd & 32'h3f, 32'h0000003c);
        $display("test standby done");
        end_sim();
    end
endmodule : test_asc_adc_ctrl
